// *** src/pthl_pkg.sv ***
// Package for the period timer with hardware limit: offsets, fields, codes
package pthl_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_CLK_SEL   = 3'h0;
  localparam logic [2:0] ADDR_CONTROL   = 3'h1;
  localparam logic [2:0] ADDR_LIMIT     = 3'h2;
  localparam logic [2:0] ADDR_RST_SEL   = 3'h3;
  localparam logic [2:0] ADDR_COUNT     = 3'h4;
  localparam logic [2:0] ADDR_PERIOD    = 3'h5;
  localparam logic [2:0] ADDR_STATUS    = 3'h6;

  // Reset values
  localparam logic [7:0] RST_CLK_SEL    = 8'h00;
  localparam logic [7:0] RST_CONTROL    = 8'h00;
  localparam logic [7:0] RST_LIMIT      = 8'h00;
  localparam logic [7:0] RST_RST_SEL    = 8'h00;
  localparam logic [7:0] RST_PERIOD     = 8'hFF;

  // Field positions
  localparam int CTL_ON_BIT    = 7;
  localparam int HLT_PRESCALE_SYNC_BIT = 7;
  localparam int HLT_POL_BIT   = 6;
  localparam int HLT_ESYNC_BIT = 5;

  // Source codes that the logic treats specially
  localparam logic [3:0] CS_RESERVED_A = 4'h7;
  localparam logic [3:0] CS_RESERVED_B = 4'hF;
  localparam logic [3:0] RS_RESERVED   = 4'hF;

  // Level-triggered hardware-limit one-shot mode codes
  localparam logic [4:0] MODE_LVL_OS_LOW  = 5'h16;
  localparam logic [4:0] MODE_LVL_OS_HIGH = 5'h17;

  // Enable-synchronization delay in input clocks
  localparam logic [1:0] ESYNC_DELAY = 2'h2;

endpackage : pthl_pkg

// *** src/pthl_timer.sv ***
// Period timer with hardware limit: registers, prescaler, counter, modes
`timescale 1ns/1ps
`default_nettype none

module pthl_timer (
  // Clock, reset, enable
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // Register port
  input  wire logic [2:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // Clock sources, indexed by clock-source code
  input  wire logic [15:0] i_clk_sources,
  // Reset sources, indexed by reset-source code
  input  wire logic [15:0] i_rst_sources,
  // Instruction-clock enable and processor sleep
  input  wire logic        i_instr_tick,
  input  wire logic        i_sleep,
  // Results
  output logic             o_match,
  output logic             o_irq_flag,
  output logic             o_pwm_start,
  output logic      [7:0]  o_count,
  output logic             o_keep_lf_osc,
  output logic             o_keep_mf_osc,
  output logic             o_keep_hf_osc
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [3:0] clk_sel_ff;
  logic [7:0] control_ff;
  logic [7:0] limit_ff;
  logic [3:0] rst_sel_ff;
  logic [7:0] period_ff;
  logic [7:0] count_ff;
  logic [6:0] pre_ff;
  logic [3:0] post_ff;
  logic       irq_ff;
  logic       clk_d_ff;
  logic       ers_d_ff;
  logic [1:0] esync_ff;
  logic       pend_ff;
  logic       running_ff;
  logic [7:0] rdata_ff;
  logic       match_ff;
  logic       pwm_ff;
  logic       clr_pend_ff;

  // Power-of-two prescale mask from the 3-bit field
  function automatic logic [6:0] pthl_pre_mask(input logic [2:0] code);
    pthl_pre_mask = 7'((8'h01 << code) - 8'h01);
  endfunction : pthl_pre_mask

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of fields and inputs
  wire        on_bit     = control_ff[pthl_pkg::CTL_ON_BIT];
  wire [2:0]  in_div     = control_ff[6:4];
  wire [3:0]  out_div    = control_ff[3:0];
  wire        prescale_sync      = limit_ff[pthl_pkg::HLT_PRESCALE_SYNC_BIT];
  wire        edge_pol   = limit_ff[pthl_pkg::HLT_POL_BIT];
  wire        esync      = limit_ff[pthl_pkg::HLT_ESYNC_BIT];
  wire [4:0]  mode       = limit_ff[4:0];
  // Reserved clock codes give no clock
  wire        cs_ok      = (clk_sel_ff != pthl_pkg::CS_RESERVED_A) &&
                           (clk_sel_ff != pthl_pkg::CS_RESERVED_B);
  wire        clk_in     = cs_ok & i_clk_sources[clk_sel_ff];
  // Reserved reset code selects a constant low input
  wire        ers        = (rst_sel_ff != pthl_pkg::RS_RESERVED) &
                           i_rst_sources[rst_sel_ff];
  // Edge on the chosen polarity of the input clock
  wire        clk_rise   = clk_in & ~clk_d_ff;
  wire        clk_fall   = ~clk_in & clk_d_ff;
  wire        in_edge    = edge_pol ? clk_fall : clk_rise;
  // Sleep freezes the timer only with prescale sync set
  wire        frozen     = i_sleep & prescale_sync;
  wire        in_tick    = in_edge & ~frozen;
  wire        pre_done   = (pre_ff == pthl_pre_mask(in_div));
  wire        raw_tick   = in_tick & pre_done;
  // With prescale sync, ticks are held until an instruction-clock enable
  wire        cnt_tick   = prescale_sync ? (pend_ff | raw_tick) & i_instr_tick
                                 : raw_tick;
  wire        lvl_mode   = (mode == pthl_pkg::MODE_LVL_OS_LOW) ||
                           (mode == pthl_pkg::MODE_LVL_OS_HIGH);
  // Reset level: low for 10110, high for 10111
  wire        at_rst_lvl = lvl_mode & (ers == mode[0]);
  wire        enabled    = on_bit & (~esync | (esync_ff == pthl_pkg::ESYNC_DELAY));
  wire        run_now    = enabled & ~at_rst_lvl;
  wire        is_match   = (count_ff == period_ff);
  wire        hit        = cnt_tick & run_now & is_match;
  wire        post_done  = (post_ff == out_div);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [7:0] rd_mux =
    (i_addr == pthl_pkg::ADDR_CLK_SEL) ? {4'h0, clk_sel_ff} :
    (i_addr == pthl_pkg::ADDR_CONTROL) ? control_ff :
    (i_addr == pthl_pkg::ADDR_LIMIT)   ? limit_ff :
    (i_addr == pthl_pkg::ADDR_RST_SEL) ? {4'h0, rst_sel_ff} :
    (i_addr == pthl_pkg::ADDR_COUNT)   ? count_ff :
    (i_addr == pthl_pkg::ADDR_PERIOD)  ? period_ff :
    (i_addr == pthl_pkg::ADDR_STATUS)  ? {6'h00, running_ff, irq_ff} :
    8'h00;

  wire wr_ctl  = i_wr & (i_addr == pthl_pkg::ADDR_CONTROL);
  wire wr_stat = i_wr & (i_addr == pthl_pkg::ADDR_STATUS);
  // Software clearing the on bit resets all timer state but the flag
  wire sw_off  = wr_ctl & ~i_wdata[pthl_pkg::CTL_ON_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; hardware clear of on bit on match in the level one-shot modes
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      clk_sel_ff <= pthl_pkg::RST_CLK_SEL[3:0];
      control_ff <= pthl_pkg::RST_CONTROL;
      limit_ff   <= pthl_pkg::RST_LIMIT;
      rst_sel_ff <= pthl_pkg::RST_RST_SEL[3:0];
      period_ff  <= pthl_pkg::RST_PERIOD;
    end else if (i_ce) begin
      if (i_wr && i_addr == pthl_pkg::ADDR_CLK_SEL) clk_sel_ff <= i_wdata[3:0];
      if (i_wr && i_addr == pthl_pkg::ADDR_LIMIT)   limit_ff   <= i_wdata;
      if (i_wr && i_addr == pthl_pkg::ADDR_RST_SEL) rst_sel_ff <= i_wdata[3:0];
      if (i_wr && i_addr == pthl_pkg::ADDR_PERIOD && !frozen)
        period_ff <= i_wdata;
      if (wr_ctl) control_ff <= i_wdata;
      if (hit && lvl_mode && !wr_ctl)
        control_ff[pthl_pkg::CTL_ON_BIT] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input edge detect, prescaler, enable synchroniser
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      clk_d_ff <= 1'b0;
      pre_ff   <= 7'h00;
      esync_ff <= 2'h0;
      pend_ff  <= 1'b0;
    end else if (i_ce) begin
      clk_d_ff <= clk_in;
      if (!on_bit || sw_off) begin
        pre_ff   <= 7'h00;
        esync_ff <= 2'h0;
        pend_ff  <= 1'b0;
      end else begin
        if (in_tick) pre_ff <= pre_done ? 7'h00 : pre_ff + 7'h01;
        // Two input clocks after on before counting
        if (in_edge && esync_ff != pthl_pkg::ESYNC_DELAY)
          esync_ff <= esync_ff + 2'h1;
        pend_ff <= prescale_sync & (pend_ff | raw_tick) & ~i_instr_tick;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, postscaler, flag, PWM start
  // Match takes effect as a clear on the following clock, which wins over a tick in that clock
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      count_ff    <= 8'h00;
      post_ff     <= 4'h0;
      irq_ff      <= 1'b0;
      running_ff  <= 1'b0;
      match_ff    <= 1'b0;
      pwm_ff      <= 1'b0;
      clr_pend_ff <= 1'b0;
    end else if (i_ce) begin
      match_ff    <= hit;
      pwm_ff      <= run_now & ~running_ff & lvl_mode;
      running_ff  <= run_now & ~(hit & lvl_mode);
      clr_pend_ff <= hit;
      if (at_rst_lvl || (lvl_mode && !on_bit) || sw_off) begin
        count_ff <= 8'h00;
        if (sw_off || !on_bit) post_ff <= 4'h0;
      end else if (clr_pend_ff) begin
        count_ff <= 8'h00;
      end else if (cnt_tick && run_now && !is_match) begin
        count_ff <= count_ff + 8'h01;
      end
      // Postscaler steps once per match; a software stop wins over it
      if (hit && !sw_off)
        post_ff <= post_done ? 4'h0 : post_ff + 4'h1;
      // Hardware set wins over a software clear
      if (hit && post_done) irq_ff <= 1'b1;
      else if (wr_stat && i_wdata[0]) irq_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) rdata_ff <= 8'h00;
    else if (i_ce) rdata_ff <= i_rd ? rd_mux : 8'h00;
  end

  // Outputs
  assign o_rdata     = rdata_ff;
  assign o_match     = match_ff;
  assign o_irq_flag  = irq_ff;
  assign o_pwm_start = pwm_ff;
  assign o_count     = count_ff;
  // Internal oscillators stay alive in sleep when selected and prescale sync is clear
  assign o_keep_lf_osc = i_sleep & ~prescale_sync & (clk_sel_ff == 4'h4);
  assign o_keep_mf_osc = i_sleep & ~prescale_sync &
                         (clk_sel_ff == 4'h5 || clk_sel_ff == 4'h6);
  assign o_keep_hf_osc = i_sleep & ~prescale_sync & (clk_sel_ff == 4'h3);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Checks look one clock after their cause, except rs_reserved_a (same clock) and match_clr_a (two clocks); clears and software writes
  // that legitimately win are carved out of the antecedent on purpose.

  hold_clear_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && at_rst_lvl |=> count_ff == 8'h00)
    else $error("counter not held clear at reset level");
  start_run_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && run_now && lvl_mode |=> running_ff || match_ff)
    else $error("count did not start");
  match_off_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && hit && lvl_mode && !wr_ctl |=> !control_ff[7])
    else $error("on bit not cleared on match");
  off_hold_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && lvl_mode && !on_bit |=> count_ff == 8'h00)
    else $error("counter not held after off");
  pwm_start_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    o_pwm_start |-> $past(run_now) && !$past(running_ff))
    else $error("pwm start without count start");
  sleep_hold_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && frozen && !clr_pend_ff && !at_rst_lvl && on_bit
      |=> $stable(count_ff))
    else $error("counter moved in synced sleep");
  irq_set_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && hit && post_done |=> o_irq_flag)
    else $error("flag not raised");
  match_clr_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && hit ##1 i_ce |=> count_ff == 8'h00)
    else $error("counter not cleared after match");
  // Period register is untouchable while frozen
  period_keep_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && frozen |=> $stable(period_ff))
    else $error("period changed in synced sleep");
  // Without prescale sync a tick in sleep still counts
  sleep_run_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && i_sleep && !prescale_sync && raw_tick && run_now && !is_match &&
      !clr_pend_ff && !sw_off
      |=> count_ff == $past(count_ff) + 8'h01)
    else $error("counter stopped in unsynced sleep");
  // Reserved clock codes never produce an edge
  cs_reserved_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && !cs_ok |=> !clk_d_ff)
    else $error("reserved clock code passed a clock");
  // Writing the on bit low clears every counter
  off_reset_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && sw_off
      |=> count_ff == 8'h00 && pre_ff == 7'h00 && post_ff == 4'h0)
    else $error("software stop left state behind");
  // Off means not running
  off_idle_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && !on_bit |=> !running_ff)
    else $error("running while off");
  // Prescaler steps on each accepted edge
  pre_step_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && on_bit && !sw_off && in_tick && !pre_done
      |=> pre_ff == $past(pre_ff) + 7'h01)
    else $error("prescaler did not step");
  // Prescaler wraps at the power-of-two limit
  pre_wrap_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && on_bit && !sw_off && in_tick && pre_done
      |=> pre_ff == 7'h00)
    else $error("prescaler did not wrap");
  // Postscaler steps on each match below its limit
  post_step_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && hit && !post_done && !sw_off |=> post_ff == $past(post_ff) + 4'h1)
    else $error("postscaler did not step");
  // Postscaler wraps after field plus one matches
  post_wrap_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && hit && post_done && !sw_off |=> post_ff == 4'h0)
    else $error("postscaler did not wrap");
  // With prescale sync the count only moves on an instruction tick
  sync_wait_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && prescale_sync && !i_instr_tick && !sw_off && !at_rst_lvl &&
      !(lvl_mode && !on_bit) && !clr_pend_ff
      |=> $stable(count_ff))
    else $error("count moved between instruction ticks");
  // Only an edge of the chosen polarity moves the prescaler
  edge_only_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && on_bit && !sw_off && !in_edge |=> $stable(pre_ff))
    else $error("prescaler moved without an edge");
  // No running before the enable synchroniser completes
  esync_wait_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && esync && esync_ff != pthl_pkg::ESYNC_DELAY |=> !running_ff)
    else $error("ran before enable sync");
  // Synchroniser counts input edges after on
  esync_step_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && on_bit && !sw_off && in_edge && esync_ff != pthl_pkg::ESYNC_DELAY
      |=> esync_ff == $past(esync_ff) + 2'h1)
    else $error("enable sync did not count");
  // Off outside the level modes keeps the count
  halt_keep_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && !lvl_mode && !on_bit && !wr_ctl && !clr_pend_ff
      |=> $stable(count_ff))
    else $error("count changed while halted");
  // Reserved reset code reads as a low input
  rs_reserved_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    rst_sel_ff == pthl_pkg::RS_RESERVED |-> !ers)
    else $error("reserved reset code passed a level");
  // Counter steps by one on every counting tick
  cnt_step_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && cnt_tick && run_now && !is_match && !clr_pend_ff && !sw_off
      |=> count_ff == $past(count_ff) + 8'h01)
    else $error("counter did not step");
  // Flag moves only on completion or a software clear
  irq_keep_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && !(hit && post_done) && !(wr_stat && i_wdata[0])
      |=> $stable(irq_ff))
    else $error("flag changed without cause");
  // Upper select bits always read zero
  upper_zero_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && i_rd && (i_addr == pthl_pkg::ADDR_CLK_SEL ||
      i_addr == pthl_pkg::ADDR_RST_SEL) |=> o_rdata[7:4] == 4'h0)
    else $error("upper select bits not zero");
  // Read port is zero outside the answer cycle
  rd_idle_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside answer cycle");
  // Count read returns the count of the strobe cycle
  rd_count_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_ce && i_rd && i_addr == pthl_pkg::ADDR_COUNT |=> o_rdata == $past(count_ff))
    else $error("count read wrong");

endmodule : pthl_timer

`default_nettype wire

// *** verification/pthl_src_model.sv ***
// Model of the on-chip clock and reset sources feeding the timer
`timescale 1ns/1ps
`default_nettype none

module pthl_src_model (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Level put on every reset source
  input  wire logic        i_level,
  // Source buses
  output logic      [15:0] o_clk_sources,
  output logic      [15:0] o_rst_sources
);
  logic [1:0] div_ff;
  logic       tclk_ff;

  // Slow clock, 8 system cycles a period, so edge detection never misses
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      div_ff  <= 2'h0;
      tclk_ff <= 1'b0;
    end else begin
      div_ff <= div_ff + 2'h1;
      if (div_ff == 2'h3) tclk_ff <= ~tclk_ff;
    end
  end

  // Every code sees the same sources; reserved codes are ignored inside
  assign o_clk_sources = {16{tclk_ff}};
  assign o_rst_sources = {16{i_level}};
endmodule : pthl_src_model
`default_nettype wire

// *** verification/tb_pthl_timer.sv ***
// Self-checking bench for the period timer with hardware limit
`timescale 1ns/1ps
`default_nettype none

module tb_pthl_timer;
  logic        clk, rst, wr_en, rd_en, tick, sleep, lvl, match, irq, pwm, klf;
  logic        ce, kmf, khf;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, cnt, d, e;
  logic [15:0] csrc, rsrc;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          n;

  pthl_timer u_dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_en), .i_rd(rd_en),
    .o_rdata(rdata), .i_clk_sources(csrc), .i_rst_sources(rsrc),
    .i_instr_tick(tick), .i_sleep(sleep), .o_match(match),
    .o_irq_flag(irq), .o_pwm_start(pwm), .o_count(cnt),
    .o_keep_lf_osc(klf), .o_keep_mf_osc(kmf), .o_keep_hf_osc(khf));

  pthl_src_model u_src (.i_clk_sys(clk), .i_rst(rst), .i_level(lvl),
    .o_clk_sources(csrc), .o_rst_sources(rsrc));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Instruction clock every fourth cycle; cycle ceiling cuts a hang short
  always @(posedge clk) begin
    tick <= (cycles % 4 == 0);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task complete_run;
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task chk8(input string nm, input logic [7:0] ex, input logic [7:0] g);
    total_checks++;
    if (g !== ex) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk8

  task chkn(input string nm, input int ex, input int g);
    total_checks++;
    if (g != ex) begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", nm, ex, g);
    end
  endtask : chkn

  task bus_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe
  task bus_rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask : bus_rd

  // Cycles until a pulse (0 match, 1 drive start), -1 if none in lim
  task wpulse(input int sel, input int lim, output int k);
    logic s;
    k = 0;
    s = 1'b0;
    while (s !== 1'b1 && k < lim) begin
      @(posedge clk);
      #1 k++;
      s = (sel == 0) ? match : pwm;
    end
    if (s !== 1'b1) k = -1;
  endtask : wpulse

  task t_regs;
    for (int a = 0; a < 4; a++) begin
      bus_rd(a[2:0], d);
      chk8("reset value", 8'h00, d);
    end
    bus_rd(pthl_pkg::ADDR_PERIOD, d);
    chk8("period reset", 8'hFF, d);
    bus_wr(pthl_pkg::ADDR_CLK_SEL, 8'hFF);
    bus_rd(pthl_pkg::ADDR_CLK_SEL, d);
    chk8("clock select", 8'h0F, d);
    bus_wr(pthl_pkg::ADDR_RST_SEL, 8'hFF);
    bus_rd(pthl_pkg::ADDR_RST_SEL, d);
    chk8("reset select", 8'h0F, d);
    bus_rd(3'h7, d);
    chk8("unmapped", 8'h00, d);
    bus_wr(pthl_pkg::ADDR_CLK_SEL, 8'h00);
    bus_wr(pthl_pkg::ADDR_RST_SEL, 8'h00);
  endtask : t_regs

  // Period 3, postscale 1:2: flag only after the second match
  task t_post;
    bus_wr(pthl_pkg::ADDR_PERIOD, 8'h03);
    bus_wr(pthl_pkg::ADDR_CONTROL, 8'h81);
    wpulse(0, 400, n);
    repeat (3) @(posedge clk);
    #1 chk8("flag early", 8'h00, {7'h00, irq});
    wpulse(0, 400, n);
    repeat (3) @(posedge clk);
    #1 chk8("flag set", 8'h01, {7'h00, irq});
    bus_wr(pthl_pkg::ADDR_STATUS, 8'h01);
    #1 chk8("flag clear", 8'h00, {7'h00, irq});
  endtask : t_post

  // Match spacing is (period+1) input clocks of 8 cycles times prescale
  task t_presc;
    for (int p = 0; p < 3; p++) begin
      bus_wr(pthl_pkg::ADDR_CONTROL, 8'h00);
      bus_wr(pthl_pkg::ADDR_CONTROL, {1'b1, p[2:0], 4'h0});
      wpulse(0, 2000, n);
      wpulse(0, 2000, n);
      chkn("match interval", 32 << p, n);
    end
    bus_wr(pthl_pkg::ADDR_CONTROL, 8'h00);
    bus_rd(pthl_pkg::ADDR_COUNT, d);
    chk8("count after off", 8'h00, d);
  endtask : t_presc

  // Polarity bit stays 0 throughout, never changed while on
  task t_oneshot;
    bus_wr(pthl_pkg::ADDR_PERIOD, 8'h05);
    bus_wr(pthl_pkg::ADDR_LIMIT, {3'h0, pthl_pkg::MODE_LVL_OS_HIGH});
    lvl <= 1'b1;
    bus_wr(pthl_pkg::ADDR_CONTROL, 8'h80);
    wpulse(1, 100, n);
    chkn("start while held", -1, n);
    bus_rd(pthl_pkg::ADDR_COUNT, d);
    chk8("count held", 8'h00, d);
    @(posedge clk);
    lvl <= 1'b0;
    wpulse(1, 40, n);
    chkn("start on release", 1, int'(n > 0));
    wpulse(0, 400, n);
    chkn("one-shot match", 1, int'(n > 0));
    bus_rd(pthl_pkg::ADDR_CONTROL, d);
    chk8("on cleared", 8'h00, d);
    wpulse(1, 100, n);
    chkn("no restart", -1, n);
    bus_rd(pthl_pkg::ADDR_COUNT, d);
    chk8("count stays", 8'h00, d);
    bus_wr(pthl_pkg::ADDR_CONTROL, 8'h80);
    wpulse(1, 40, n);
    chkn("start on set", 1, int'(n > 0));
    bus_wr(pthl_pkg::ADDR_CONTROL, 8'h00);
  endtask : t_oneshot

  task t_sleep;
    bus_wr(pthl_pkg::ADDR_CLK_SEL, 8'h04);
    bus_wr(pthl_pkg::ADDR_PERIOD, 8'hFF);
    bus_wr(pthl_pkg::ADDR_LIMIT, 8'h00);
    bus_wr(pthl_pkg::ADDR_CONTROL, 8'h80);
    @(posedge clk);
    sleep <= 1'b1;
    #1 chk8("keep osc", 8'h04, {5'h00, klf, kmf, khf});
    bus_rd(pthl_pkg::ADDR_COUNT, d);
    repeat (50) @(posedge clk);
    bus_rd(pthl_pkg::ADDR_COUNT, e);
    chkn("runs in sleep", 1, int'(e !== d));
    bus_wr(pthl_pkg::ADDR_LIMIT, 8'h80);
    bus_rd(pthl_pkg::ADDR_COUNT, d);
    repeat (50) @(posedge clk);
    bus_rd(pthl_pkg::ADDR_COUNT, e);
    chk8("frozen count", d, e);
    chk8("count pin", e, cnt);
    bus_wr(pthl_pkg::ADDR_PERIOD, 8'h10);
    bus_rd(pthl_pkg::ADDR_PERIOD, d);
    chk8("period kept", 8'hFF, d);
    sleep <= 1'b0;
  endtask : t_sleep

  // Falling-edge clocking with the on bit synchronised to the input clock
  task t_esync;
    bus_wr(pthl_pkg::ADDR_CONTROL, 8'h00);
    bus_wr(pthl_pkg::ADDR_LIMIT, 8'h60);
    bus_wr(pthl_pkg::ADDR_CONTROL, 8'h80);
    bus_rd(pthl_pkg::ADDR_STATUS, d);
    chk8("running before sync", 8'h00, d & 8'h02);
    repeat (40) @(posedge clk);
    bus_rd(pthl_pkg::ADDR_STATUS, d);
    chk8("running after sync", 8'h02, d & 8'h02);
    bus_wr(pthl_pkg::ADDR_CONTROL, 8'h00);
    bus_wr(pthl_pkg::ADDR_LIMIT, 8'h00);
  endtask : t_esync

  // Clock enable low freezes every register, counter included
  task t_hold;
    bus_wr(pthl_pkg::ADDR_CONTROL, 8'h80);
    repeat (20) @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    #1 d = cnt;
    repeat (40) @(posedge clk);
    #1 chk8("count with ce low", d, cnt);
    @(posedge clk);
    ce <= 1'b1;
    repeat (40) @(posedge clk);
    #1 chkn("count with ce high", 1, int'(cnt !== d));
    bus_wr(pthl_pkg::ADDR_CONTROL, 8'h00);
  endtask : t_hold

  initial begin
    rst   = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 3'h0;
    wdata = 8'h00;
    sleep = 1'b0;
    lvl   = 1'b0;
    ce    = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_post;
    t_presc;
    t_oneshot;
    t_sleep;
    t_esync;
    t_hold;
    complete_run;
  end
endmodule : tb_pthl_timer
`default_nettype wire
